// ---- logic/dosac_pkg.sv ----
// Constants, field layout and types for the termination control pair.
// Assumes a single 125 MHz clock shared by controller and memory model.
//
// Behaviour
// - Synchronous mode needs locked DLL and termination.
// - Synchronous in active states and active power-down.
// - Termination follows pin after on/off latency.
// - Both latencies equal write latency minus two.
// - Additive latency adds into both latencies.
// - Pin stays high four cycles after assertion.
// - Write with pin high holds four/six cycles.
// - Release only after the later hold window.
// - Pin low before read so termination drops.
// - No termination before read postamble ends.
// - DLL parked in precharge power-down means asynchronous.
// - DLL resynchronizing also means asynchronous.
// - Asynchronous path skips additive latency, 2-8.5 ns.
// - Write termination enabled by either bit.
package dosac_pkg;

    // ---------------------------------------------------------------
    // Timing
    // ---------------------------------------------------------------
    localparam int CLK_PERIOD_PS = 8000;
    localparam int ASYNC_MIN_PS  = 2000;
    localparam int ASYNC_MAX_PS  = 8500;
    localparam int ASYNC_MIN_CYC = (ASYNC_MIN_PS + CLK_PERIOD_PS - 1)
                                   / CLK_PERIOD_PS;
    localparam int ASYNC_MAX_CYC = (ASYNC_MAX_PS / CLK_PERIOD_PS) < 1 ? 1
                                   : ASYNC_MAX_PS / CLK_PERIOD_PS;
    localparam int DLL_LOCK_CYC  = 512;
    localparam int HOLD_SHORT    = 4;
    localparam int HOLD_LONG     = 6;
    localparam int LAT_OFFSET    = 2;
    localparam int READ_TAIL     = 7;
    localparam int CL_BASE       = 5;
    localparam int CWL_BASE      = 5;
    localparam int LAT_DEPTH     = 32;
    localparam int LAT_W         = 5;
    localparam int CNT_W         = 10;

    // ---------------------------------------------------------------
    // Mode register fields
    // ---------------------------------------------------------------
    localparam int MR_W         = 13;
    localparam int MR0_CL_LSB   = 4;
    localparam int MR0_DLL_RST  = 8;
    localparam int MR0_DLL_SEL  = 12;
    localparam int MR1_DLL_DIS  = 0;
    localparam int MR1_NOM_B0   = 2;
    localparam int MR1_AL_LSB   = 3;
    localparam int MR1_NOM_B1   = 6;
    localparam int MR1_NOM_B2   = 9;
    localparam int MR2_CWL_LSB  = 3;
    localparam int MR2_WR_LSB   = 9;
    localparam logic [1:0] AL_CL_M1 = 2'h1;
    localparam logic [1:0] AL_CL_M2 = 2'h2;
    localparam logic [1:0] MR_SEL0  = 2'h0;
    localparam logic [1:0] MR_SEL1  = 2'h1;
    localparam logic [1:0] MR_SEL2  = 2'h2;

    // ---------------------------------------------------------------
    // Controller register map and fields
    // ---------------------------------------------------------------
    localparam logic [7:0] ADDR_CTRL   = 8'h00;
    localparam logic [7:0] ADDR_CMD    = 8'h04;
    localparam logic [7:0] ADDR_STATUS = 8'h08;
    localparam int CTRL_TERM   = 0;
    localparam int CTRL_CKE    = 1;
    localparam int CMD_CODE_LSB = 0;
    localparam int CMD_BC4     = 3;
    localparam int CMD_SEL_LSB = 4;
    localparam int CMD_DATA_LSB = 6;

    typedef enum logic [2:0] {
        CMD_NOP, CMD_ACT, CMD_PRE, CMD_WR, CMD_RD, CMD_MRS
    } dosac_cmd_t;

    typedef enum logic [1:0] {
        DLL_OFF, DLL_RESYNC, DLL_LOCKED
    } dosac_dll_t;

endpackage : dosac_pkg

// ---- logic/dosac_if.sv ----
// Link between memory controller and memory termination logic.
// Assumes both ends share one clock; all signals change after its edge.
`timescale 1ns/1ps
interface dosac_if;
    import dosac_pkg::*;
    logic             termRequest;
    logic             cke;
    logic             cmdValid;
    dosac_cmd_t       cmd;
    logic             cmdBurstChop;
    logic [1:0]       cmdMrSel;
    logic [MR_W-1:0]  cmdMrData;

    modport ctl (
        output termRequest, cke, cmdValid, cmd, cmdBurstChop,
        output cmdMrSel, cmdMrData
    );
    modport dev (
        input termRequest, cke, cmdValid, cmd, cmdBurstChop,
        input cmdMrSel, cmdMrData
    );
endinterface : dosac_if

// ---- logic/dosac_delay_line.sv ----
// Shift line of sampled pin levels with a selectable tap.
// Assumes the tap is below the depth; tap 0 is the last sample.
`timescale 1ns/1ps
module dosac_delay_line (
    input  wire logic                      clock,
    input  wire logic                      rst_b,
    input  wire logic                      din,
    input  wire logic [dosac_pkg::LAT_W-1:0] tap,
    output logic                           dout
);
    import dosac_pkg::*;

    logic [LAT_DEPTH-1:0] stage_r;
    logic [LAT_DEPTH:0]   chain;

    // Input at bit 0 keeps every stage index in range
    assign chain = {stage_r, din};

    genvar i;
    generate
        for (i = 0; i < LAT_DEPTH; i++) begin : g_stage
            always_ff @(posedge clock or negedge rst_b) begin
                if (!rst_b) begin
                    stage_r[i] <= 1'b0;
                end else begin
                    stage_r[i] <= chain[i];
                end
            end
        end
    endgenerate

    assign dout = stage_r[tap];
endmodule : dosac_delay_line

// ---- logic/dosac_device.sv ----
// Memory-side termination control: decodes mode registers, tracks DLL
// and power-down state, and switches termination from the request pin.
// Assumes the controller honours the pin hold and read spacing duties.
`timescale 1ns/1ps
module dosac_device #(
    parameter int LOCK_CYCLES = dosac_pkg::DLL_LOCK_CYC
) (
    input  wire logic         clock,
    input  wire logic         rst_b,
    dosac_if.dev              link,
    output logic              termActive,
    output logic              asyncMode,
    output logic              dllLocked,
    output logic [dosac_pkg::LAT_W-1:0] termLatency
);
    import dosac_pkg::*;

    // ------------
    // Mode register shadows
    // ------------
    logic [2:0]  clCode_r;
    logic        dllSel_r;
    logic        dllDis_r;
    logic [2:0]  nomTerm_r;
    logic [1:0]  alCode_r;
    logic [2:0]  cwlCode_r;
    logic [1:0]  wrTerm_r;
    logic        dllRstReq;
    logic        mrsHit;

    assign mrsHit = link.cmdValid && (link.cmd == CMD_MRS);
    assign dllRstReq = mrsHit && (link.cmdMrSel == MR_SEL0)
                       && link.cmdMrData[MR0_DLL_RST];

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            clCode_r  <= 3'h0;
            dllSel_r  <= 1'b0;
        end else if (mrsHit && link.cmdMrSel == MR_SEL0) begin
            clCode_r  <= link.cmdMrData[MR0_CL_LSB +: 3];
            dllSel_r  <= link.cmdMrData[MR0_DLL_SEL];
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            dllDis_r  <= 1'b0;
            nomTerm_r <= 3'h0;
            alCode_r  <= 2'h0;
        end else if (mrsHit && link.cmdMrSel == MR_SEL1) begin
            dllDis_r  <= link.cmdMrData[MR1_DLL_DIS];
            nomTerm_r <= {link.cmdMrData[MR1_NOM_B2],
                          link.cmdMrData[MR1_NOM_B1],
                          link.cmdMrData[MR1_NOM_B0]};
            alCode_r  <= link.cmdMrData[MR1_AL_LSB +: 2];
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            cwlCode_r <= 3'h0;
            wrTerm_r  <= 2'h0;
        end else if (mrsHit && link.cmdMrSel == MR_SEL2) begin
            cwlCode_r <= link.cmdMrData[MR2_CWL_LSB +: 3];
            wrTerm_r  <= link.cmdMrData[MR2_WR_LSB +: 2];
        end
    end

    // ------------
    // Latency arithmetic
    // ------------
    logic [LAT_W-1:0] clCyc;
    logic [LAT_W-1:0] cwlCyc;
    logic [LAT_W-1:0] alCyc;
    logic [LAT_W-1:0] syncLat;

    assign clCyc  = LAT_W'(clCode_r) + LAT_W'(CL_BASE);
    assign cwlCyc = LAT_W'(cwlCode_r) + LAT_W'(CWL_BASE);

    always_comb begin
        case (alCode_r)
            AL_CL_M1: alCyc = clCyc - LAT_W'(1);
            AL_CL_M2: alCyc = clCyc - LAT_W'(2);
            default:  alCyc = '0;
        endcase
    end

    // Same figure for turn-on and turn-off
    assign syncLat = cwlCyc + alCyc - LAT_W'(LAT_OFFSET);

    // ------------
    // Bank and power-down tracking
    // ------------
    logic cke_r;
    logic bankOpen_r;
    logic prePowerDown;
    logic dllParked;

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            cke_r <= 1'b0;
        end else begin
            cke_r <= link.cke;
        end
    end

    // Only a precharge-all is modelled, so one flag covers all banks
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            bankOpen_r <= 1'b0;
        end else if (link.cmdValid && link.cmd == CMD_ACT) begin
            bankOpen_r <= 1'b1;
        end else if (link.cmdValid && link.cmd == CMD_PRE) begin
            bankOpen_r <= 1'b0;
        end
    end

    assign prePowerDown = !cke_r && !bankOpen_r;
    // Active power-down never parks the DLL
    assign dllParked = prePowerDown && !dllSel_r;

    // ------------
    // DLL state
    // ------------
    dosac_dll_t        dll_r;
    logic [CNT_W-1:0]  lockCnt_r;

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            dll_r     <= DLL_RESYNC;
            lockCnt_r <= '0;
        end else begin
            case (dll_r)
                DLL_OFF: begin
                    if (!dllDis_r) begin
                        dll_r     <= DLL_RESYNC;
                        lockCnt_r <= '0;
                    end
                end
                DLL_RESYNC: begin
                    if (dllDis_r) begin
                        dll_r <= DLL_OFF;
                    end else if (int'(lockCnt_r) >= LOCK_CYCLES - 1) begin
                        dll_r <= DLL_LOCKED;
                    end else begin
                        lockCnt_r <= lockCnt_r + CNT_W'(1);
                    end
                end
                DLL_LOCKED: begin
                    if (dllDis_r) begin
                        dll_r <= DLL_OFF;
                    end else if (dllRstReq) begin
                        dll_r     <= DLL_RESYNC;
                        lockCnt_r <= '0;
                    end
                end
                default: begin
                    dll_r <= DLL_OFF;
                end
            endcase
        end
    end

    // ------------
    // Mode selection
    // ------------
    logic termEnabled;
    logic wrTermOn;
    logic syncSel;

    assign wrTermOn    = wrTerm_r[0] || wrTerm_r[1];
    assign termEnabled = (nomTerm_r != 3'h0) || wrTermOn;
    // Resync and parked DLL both fall back to analog timing
    assign syncSel = termEnabled && (dll_r == DLL_LOCKED)
                     && !dllParked;

    // ------------
    // Pin delay and termination output
    // ------------
    logic [LAT_W-1:0] tapSel;
    logic             delayed;

    // Async tap skips the additive part entirely
    assign tapSel = syncSel ? syncLat - LAT_W'(1)
                            : LAT_W'(ASYNC_MAX_CYC - 1);

    dosac_delay_line u_line (
        .clock (clock),
        .rst_b (rst_b),
        .din   (link.termRequest),
        .tap   (tapSel),
        .dout  (delayed)
    );

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            termActive <= 1'b0;
        end else if (!termEnabled) begin
            termActive <= 1'b0;
        end else begin
            termActive <= delayed;
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            asyncMode   <= 1'b1;
            dllLocked   <= 1'b0;
            termLatency <= '0;
        end else begin
            asyncMode   <= !syncSel;
            dllLocked   <= (dll_r == DLL_LOCKED);
            termLatency <= syncLat;
        end
    end
endmodule : dosac_device

// ---- logic/dosac_controller.sv ----
// Controller end: AHB-Lite registers, pin hold windows, read spacing.
// Assumes a zero-wait bus; one command is queued at a time.
`timescale 1ns/1ps
module dosac_controller (
    input  wire logic        clock,
    input  wire logic        rst_b,
    dosac_if.ctl             link,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic [31:0]      hrdata,
    output logic             hresp
);
    import dosac_pkg::*;

    // ------------
    // Bus slave
    // ------------
    logic        wrPend_r;
    logic [7:0]  wrAddr_r;
    logic        termWant_r;
    logic        cke_r;
    logic        pendValid_r;
    dosac_cmd_t  pendCmd_r;
    logic        pendBc4_r;
    logic [1:0]  pendSel_r;
    logic [MR_W-1:0] pendData_r;
    logic        pin_r;
    logic [2:0]  hold_r;
    logic [4:0]  blk_r;
    logic [4:0]  lowCnt_r;
    logic        addrPhase;
    logic        issue;

    assign addrPhase = hsel && htrans[1] && hready;

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            wrPend_r  <= 1'b0;
            wrAddr_r  <= 8'h00;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
            hrdata    <= 32'h0;
        end else begin
            wrPend_r <= addrPhase && hwrite;
            if (addrPhase) begin
                wrAddr_r <= haddr[7:0];
            end
            hrdata <= 32'h0;
            if (addrPhase && !hwrite) begin
                case (haddr[7:0])
                    ADDR_CTRL: hrdata <= {30'h0, cke_r, termWant_r};
                    ADDR_STATUS: hrdata <= {28'h0, blk_r != 5'h0,
                                            hold_r > 3'h1, pin_r,
                                            pendValid_r};
                    default: hrdata <= 32'h0;
                endcase
            end
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            termWant_r <= 1'b0;
            cke_r      <= 1'b0;
        end else if (wrPend_r && wrAddr_r == ADDR_CTRL) begin
            termWant_r <= hwdata[CTRL_TERM];
            cke_r      <= hwdata[CTRL_CKE];
        end
    end

    // Writes to the command word while busy are dropped
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            pendValid_r <= 1'b0;
            pendCmd_r   <= CMD_NOP;
            pendBc4_r   <= 1'b0;
            pendSel_r   <= 2'h0;
            pendData_r  <= '0;
        end else if (issue) begin
            pendValid_r <= 1'b0;
        end else if (wrPend_r && wrAddr_r == ADDR_CMD && !pendValid_r) begin
            pendValid_r <= 1'b1;
            pendCmd_r   <= dosac_cmd_t'(hwdata[CMD_CODE_LSB +: 3]);
            pendBc4_r   <= hwdata[CMD_BC4];
            pendSel_r   <= hwdata[CMD_SEL_LSB +: 2];
            pendData_r  <= hwdata[CMD_DATA_LSB +: MR_W];
        end
    end

    // ------------
    // Latency shadows for read spacing
    // ------------
    logic [2:0] clCode_r;
    logic [2:0] cwlCode_r;
    logic [4:0] guard;
    logic [4:0] tail;

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            clCode_r  <= 3'h0;
            cwlCode_r <= 3'h0;
        end else if (issue && pendCmd_r == CMD_MRS) begin
            if (pendSel_r == MR_SEL0) begin
                clCode_r <= pendData_r[MR0_CL_LSB +: 3];
            end
            if (pendSel_r == MR_SEL2) begin
                cwlCode_r <= pendData_r[MR2_CWL_LSB +: 3];
            end
        end
    end

    // Base offsets cancel, so codes compare directly
    assign guard = (cwlCode_r > clCode_r)
                   ? 5'(cwlCode_r - clCode_r) : 5'h0;
    assign tail  = (5'(clCode_r) + 5'(READ_TAIL) > 5'(cwlCode_r))
                   ? 5'(clCode_r) + 5'(READ_TAIL) - 5'(cwlCode_r) : 5'h0;

    // ------------
    // Pin and command issue
    // ------------
    logic readWait;
    logic pinNxt;
    logic [2:0] holdDec;
    logic [2:0] wrHold;

    assign readWait = pendValid_r && pendCmd_r == CMD_RD;
    assign issue = pendValid_r && (!readWait
                   || (!pin_r && lowCnt_r >= guard));
    // A read ahead forces the pin down once holds run out
    assign pinNxt = (termWant_r && !readWait && blk_r == 5'h0)
                    || (pin_r && hold_r > 3'h1);
    assign holdDec = (hold_r != 3'h0) ? hold_r - 3'h1 : 3'h0;
    assign wrHold = pendBc4_r ? 3'(HOLD_SHORT) : 3'(HOLD_LONG);

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            pin_r  <= 1'b0;
            hold_r <= 3'h0;
        end else begin
            pin_r <= pinNxt;
            if (!pinNxt) begin
                hold_r <= 3'h0;
            end else if (!pin_r) begin
                hold_r <= 3'(HOLD_SHORT);
            end else if (issue && pendCmd_r == CMD_WR
                         && wrHold > holdDec) begin
                hold_r <= wrHold;
            end else begin
                hold_r <= holdDec;
            end
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            lowCnt_r <= 5'h0;
            blk_r    <= 5'h0;
        end else begin
            lowCnt_r <= pin_r ? 5'h0 : lowCnt_r + {4'h0, lowCnt_r != 5'h1F};
            if (issue && pendCmd_r == CMD_RD) begin
                blk_r <= tail;
            end else if (blk_r != 5'h0) begin
                blk_r <= blk_r - 5'h1;
            end
        end
    end

    assign link.termRequest = pin_r;
    assign link.cke = cke_r;

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            link.cmdValid     <= 1'b0;
            link.cmd          <= CMD_NOP;
            link.cmdBurstChop <= 1'b0;
            link.cmdMrSel     <= 2'h0;
            link.cmdMrData    <= '0;
        end else begin
            link.cmdValid     <= issue;
            link.cmd          <= issue ? pendCmd_r : CMD_NOP;
            link.cmdBurstChop <= pendBc4_r;
            link.cmdMrSel     <= pendSel_r;
            link.cmdMrData    <= pendData_r;
        end
    end
endmodule : dosac_controller

// ---- tb/dosac_checker.sv ----
// Assertions on the termination link and the memory-side outputs.
// Assumes one clock; tb_top instantiates it beside the link.
`timescale 1ns/1ps
module dosac_checker (
    input wire logic                    clock,
    input wire logic                    rst_b,
    input wire logic                    termRequest,
    input wire logic                    cmdValid,
    input wire dosac_pkg::dosac_cmd_t   cmd,
    input wire logic                    cmdBurstChop,
    input wire logic                    termActive,
    input wire logic                    asyncMode,
    input wire logic                    dllLocked,
    input wire logic [dosac_pkg::LAT_W-1:0] termLatency
);
    import dosac_pkg::*;
    // ---------------------------------------------------------------
    // Pin history, so a variable latency can be looked up
    // ---------------------------------------------------------------
    logic [LAT_DEPTH-1:0] pinHist_r;
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) pinHist_r <= '0;
        else pinHist_r <= {pinHist_r[LAT_DEPTH-2:0], termRequest};
    end
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_b);
    property p_hold_on;
        $rose(termRequest) |-> termRequest [*4];
    endproperty
    property p_hold_wr8;
        cmdValid && cmd == CMD_WR && termRequest && !cmdBurstChop
            |-> termRequest [*6];
    endproperty
    property p_hold_wr4;
        cmdValid && cmd == CMD_WR && termRequest && cmdBurstChop
            |-> termRequest [*4];
    endproperty
    property p_rd_off;
        cmdValid && cmd == CMD_RD |-> !termRequest;
    endproperty
    property p_rd_post;
        cmdValid && cmd == CMD_RD |=> !termRequest [*3];
    endproperty
    // Mode changes mid-flight would blur the lookup, so skip them
    property p_sync_lat;
        $changed(termActive) && !asyncMode && $stable(asyncMode)
            |-> termActive == pinHist_r[termLatency];
    endproperty
    property p_async;
        $changed(termActive) && asyncMode && $past(asyncMode)
            |-> termActive == $past(termRequest, 2);
    endproperty
    property p_resync;
        !dllLocked |-> asyncMode;
    endproperty
    a_hold_on: assert property (p_hold_on)
        else $error("pin released inside hold after assertion");
    a_hold_wr8: assert property (p_hold_wr8)
        else $error("pin released inside long write hold");
    a_hold_wr4: assert property (p_hold_wr4)
        else $error("pin released inside short write hold");
    a_rd_off: assert property (p_rd_off)
        else $error("read issued with pin high");
    a_rd_post: assert property (p_rd_post)
        else $error("pin raised too soon after read");
    a_sync_lat: assert property (p_sync_lat)
        else $error("termination not at synchronous latency");
    a_async: assert property (p_async)
        else $error("asynchronous termination not one cycle");
    a_resync: assert property (p_resync)
        else $error("synchronous mode while DLL unlocked");
    c_wr8: cover property (cmdValid && cmd == CMD_WR && !cmdBurstChop);
    c_rd: cover property (cmdValid && cmd == CMD_RD);
    c_async: cover property (asyncMode && $changed(termActive));
endmodule : dosac_checker

// ---- tb/tb_top.sv ----
// Self-checking bench: controller and memory end joined by the link.
// Assumes a zero-wait AHB-Lite slave and a short DLL lock count.
`timescale 1ns/1ps
module tb_top;
    import dosac_pkg::*;
    typedef struct packed {logic [31:0] e; logic [31:0] m;} dosac_rd_t;
    logic        clock = 1'b0;
    logic        rst_b = 1'b0;
    logic        hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0]  htrans = 2'h0;
    logic        hwrite = 1'b0;
    logic [2:0]  hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic        hreadyout, hresp, termActive, asyncMode, dllLocked;
    logic [31:0] hrdata, lastRd, q;
    logic [LAT_W-1:0] termLatency;
    logic        rdPend = 1'b0;
    logic        ckeW = 1'b0;
    dosac_rd_t   rdE;
    dosac_rd_t   rdQ[$];
    logic        taQ[$];
    int          n_fail = 0;
    int          cmp_count = 0;
    int          k;
    always #4 clock = ~clock;
    dosac_if dosac_if_i ();
    dosac_controller dosac_controller_i (.clock(clock), .rst_b(rst_b),
        .link(dosac_if_i), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata),
        .hresp(hresp));
    dosac_device #(.LOCK_CYCLES(8)) dosac_device_i (.clock(clock),
        .rst_b(rst_b), .link(dosac_if_i), .termActive(termActive),
        .asyncMode(asyncMode), .dllLocked(dllLocked),
        .termLatency(termLatency));
    dosac_checker dosac_checker_i (.clock(clock), .rst_b(rst_b),
        .termRequest(dosac_if_i.termRequest), .cmdValid(dosac_if_i.cmdValid),
        .cmd(dosac_if_i.cmd), .cmdBurstChop(dosac_if_i.cmdBurstChop),
        .termActive(termActive), .asyncMode(asyncMode),
        .dllLocked(dllLocked), .termLatency(termLatency));
    // ---------------------------------------------------------------
    // Compare, bus and watch
    // ---------------------------------------------------------------
    task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task bus(input logic w, input logic [7:0] a, input logic [31:0] d,
             output logic [31:0] r);
        @(posedge clock);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {24'h0, a};
        do @(posedge clock); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clock); while (hreadyout !== 1'b1);
        #1 r = lastRd;
    endtask : bus
    task wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        bus(1'b1, a, d, r);
    endtask : wr
    task rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
        rdQ.push_back('{e, m});
        bus(1'b0, a, 32'h0, q);
    endtask : rd
    task cmdo(input logic [2:0] c, input logic bc, input logic [1:0] s,
              input logic [12:0] d);
        int i;
        wr(ADDR_CMD, {13'h0, d, s, bc, c});
        for (i = 0; i < 40; i++) begin
            rd(ADDR_STATUS, 32'h0, 32'h0);
            if (q[0] === 1'b0) break;
        end
    endtask : cmdo
    // Follow flag f: termination is expected to track the pin
    task pin(input logic v, input logic f);
        int i;
        if (f) taQ.push_back(v);
        wr(ADDR_CTRL, {30'h0, ckeW, v});
        rd(ADDR_CTRL, {30'h0, ckeW, v}, 32'h3);
        for (i = 0; i < 30 && termActive !== (f & v); i++) @(posedge clock);
    endtask : pin
    task mode(input logic [2:0] cl, input logic [1:0] al,
              input logic [2:0] cw, input logic nom, input logic [1:0] wc,
              input logic sel);
        int c;
        c = CL_BASE + cl;
        cmdo(CMD_MRS, 1'b0, MR_SEL0, {sel, 5'h0, cl, 4'h0});
        cmdo(CMD_MRS, 1'b0, MR_SEL1, {8'h0, al, nom, 2'h0});
        cmdo(CMD_MRS, 1'b0, MR_SEL2, {2'h0, wc, 3'h0, cw, 3'h0});
        c = (al == AL_CL_M1) ? c - 1 : (al == AL_CL_M2) ? c - 2 : 0;
        chk("termLatency", termLatency, CWL_BASE + cw + c - LAT_OFFSET);
    endtask : mode
    always @(posedge clock) begin
        if (rdPend && hreadyout) begin
            lastRd = hrdata;
            chk("hresp", hresp, 32'h0);
            rdE = rdQ.pop_front();
            if (rdE.m !== 32'h0) chk("hrdata", hrdata & rdE.m, rdE.e);
        end
        if (hreadyout) rdPend <= hsel && htrans[1] && !hwrite;
    end
    always @(termActive) if (rst_b === 1'b1)
        chk("termActive", termActive, taQ.size() ? taQ.pop_front() : !termActive);
    task wrap_up;
        chk("leftover", taQ.size(), 32'h0);
        $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : wrap_up
    initial begin
        #100us;
        n_fail++;
        wrap_up();
    end
    // ---------------------------------------------------------------
    // Tests
    // ---------------------------------------------------------------
    initial begin
        repeat (2) @(posedge clock);
        rst_b <= 1'b1;
        chk("asyncMode", asyncMode, 32'h1);
        k = $urandom(52);
        repeat (12) @(posedge clock);
        chk("dllLocked", dllLocked, 32'h1);
        ckeW = 1'b1;
        $display("test reset done");
        for (k = 0; k < 3; k++) begin
            mode($urandom_range(3, 0), k, $urandom_range(2, 0), 1'b1, 2'h0, 1'b1);
            chk("asyncMode", asyncMode, 32'h0);
            pin(1'b1, 1'b1);
            pin(1'b0, 1'b1);
        end
        $display("test latency done");
        mode(3'h0, 2'h0, 3'h0, 1'b1, 2'h0, 1'b1);
        cmdo(CMD_NOP, 1'b0, 2'h0, 13'h0);
        cmdo(CMD_ACT, 1'b0, 2'h0, 13'h0);
        for (k = 0; k < 2; k++) begin
            pin(1'b1, 1'b1);
            cmdo(CMD_WR, k, 2'h0, 13'h0);
            pin(1'b0, 1'b1);
        end
        $display("test write hold done");
        pin(1'b1, 1'b1);
        rd(ADDR_STATUS, 32'h2, 32'h2);
        wr(ADDR_CMD, {29'h0, CMD_RD});
        pin(1'b0, 1'b1);
        pin(1'b1, 1'b1);
        pin(1'b0, 1'b1);
        wr(8'h10, 32'hFFFFFFFF);
        rd(8'h10, 32'h0, 32'hFFFFFFFF);
        $display("test read done");
        for (k = 0; k < 3; k++) begin
            mode(3'h0, 2'h0, 3'h0, 1'b0, k, 1'b1);
            pin(1'b1, k != 0);
            pin(1'b0, k != 0);
        end
        $display("test enables done");
        mode(3'h0, 2'h0, 3'h0, 1'b1, 2'h0, 1'b0);
        cmdo(CMD_PRE, 1'b0, 2'h0, 13'h0);
        ckeW = 1'b0;
        pin(1'b0, 1'b0);
        chk("asyncMode", asyncMode, 32'h1);
        pin(1'b1, 1'b1);
        pin(1'b0, 1'b1);
        ckeW = 1'b1;
        pin(1'b0, 1'b0);
        mode(3'h0, 2'h0, 3'h0, 1'b1, 2'h0, 1'b1);
        ckeW = 1'b0;
        pin(1'b0, 1'b0);
        chk("asyncMode", asyncMode, 32'h0);
        $display("test power-down done");
        wrap_up();
    end
endmodule : tb_top
